// File: logic/flash_read_pkg.sv
// shared constants, states and opcode decoding for the serial flash read link
// assumes both link ends and the bench import it whole

package flash_read_pkg;

    // ----------------
    // opcodes
    // ----------------
    localparam logic [7:0] OP_READ       = 8'h03;
    localparam logic [7:0] OP_DUMMY_READ = 8'h0B;
    localparam logic [7:0] OP_DUAL_OUT   = 8'h3B;
    localparam logic [7:0] OP_DUAL_IO    = 8'hBB;
    localparam logic [7:0] OP_QUAD_OUT   = 8'h6B;
    localparam logic [7:0] OP_QUAD_IO    = 8'hEB;

    // ----------------
    // frame shape and timing
    // ----------------
    localparam int ADDR_W         = 24;
    localparam int OPC_BEATS      = 8;
    localparam int DUMMY_SINGLE   = 8;
    localparam int DUMMY_DIO_DEF  = 4;
    localparam int DUMMY_DIO_ALT  = 8;
    localparam int DUMMY_QIO_DEF  = 6;
    localparam int DUMMY_QIO_ALT  = 10;
    localparam int FIFO_DEPTH     = 32;
    localparam int SYS_CLK_NS     = 4;
    localparam int SCLK_PERIOD_NS = 64;
    localparam int SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * SYS_CLK_NS);

    typedef enum logic [2:0] {ST_OPC, ST_ADDR, ST_DUMMY, ST_DATA, ST_IGNORE} devState_t;
    typedef enum logic [1:0] {H_IDLE, H_RUN, H_GAP} hostState_t;

    function automatic logic opValid(input logic [7:0] op);
        return op inside {OP_READ, OP_DUMMY_READ, OP_DUAL_OUT, OP_DUAL_IO, OP_QUAD_OUT, OP_QUAD_IO};
    endfunction : opValid

    function automatic logic isQuad(input logic [7:0] op);
        return op inside {OP_QUAD_OUT, OP_QUAD_IO};
    endfunction : isQuad

    // lanes used by the address and dummy phases
    function automatic logic [2:0] addrLanes(input logic [7:0] op);
        case (op)
            OP_DUAL_IO: return 3'h2;
            OP_QUAD_IO: return 3'h4;
            default:    return 3'h1;
        endcase
    endfunction : addrLanes

    // lanes used by the data phase
    function automatic logic [2:0] dataLanes(input logic [7:0] op);
        case (op)
            OP_DUAL_OUT, OP_DUAL_IO: return 3'h2;
            OP_QUAD_OUT, OP_QUAD_IO: return 3'h4;
            default:                 return 3'h1;
        endcase
    endfunction : dataLanes

    function automatic logic [4:0] addrBeats(input logic [7:0] op);
        return 5'(ADDR_W / int'(addrLanes(op)));
    endfunction : addrBeats

    function automatic logic [3:0] dummyBeats(input logic [7:0] op, input logic dc);
        case (op)
            OP_DUMMY_READ, OP_DUAL_OUT, OP_QUAD_OUT: return 4'(DUMMY_SINGLE);
            OP_DUAL_IO: return dc ? 4'(DUMMY_DIO_ALT) : 4'(DUMMY_DIO_DEF);
            OP_QUAD_IO: return dc ? 4'(DUMMY_QIO_ALT) : 4'(DUMMY_QIO_DEF);
            default:    return 4'h0;
        endcase
    endfunction : dummyBeats

    // last beat index within one byte
    function automatic logic [2:0] byteLast(input logic [2:0] lanes);
        return 3'(8 / int'(lanes) - 1);
    endfunction : byteLast

    // io0-based enable mask for a lane count
    function automatic logic [3:0] laneMask(input logic [2:0] lanes);
        return 4'((5'h1 << lanes) - 5'h1);
    endfunction : laneMask

endpackage : flash_read_pkg

// File: logic/spi_link_if.sv
// serial link between the flash read device and its host
// assumes both ends drive enables; an undriven lane floats high (pull-up)
`timescale 1ns/1ps

interface spi_link_if;
    logic       sclk;     // serial clock, made by the host
    logic       csN;      // chip select, active low
    logic [3:0] hostOut;  // host lane values
    logic [3:0] hostOe;   // host lane enables
    logic [3:0] devOut;   // device lane values
    logic [3:0] devOe;    // device lane enables
    logic [3:0] io;       // resolved lane levels

    // device wins a clash so a late host release cannot corrupt data
    assign io = (devOe & devOut) | (~devOe & hostOe & hostOut) | (~devOe & ~hostOe);

    modport host   (output sclk, csN, hostOut, hostOe, input io);
    modport device (input sclk, csN, io, output devOut, devOe);
endinterface : spi_link_if

// File: logic/sync_fifo.sv
// single-clock FIFO with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps

module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  logic             clk_sys,   // system clock
    input  logic             srst,      // sync reset
    input  logic             inValid,   // write request
    output logic             inReady,   // room left
    input  logic [WIDTH-1:0] inData,    // write word
    output logic             outValid,  // word waiting
    input  logic             outReady,  // drain accepts
    output logic [WIDTH-1:0] outData    // head word
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrQ;
    logic [AW-1:0]    rdQ;
    logic [AW:0]      cntQ;
    logic             push;
    logic             pop;

    assign inReady  = cntQ != (AW+1)'(DEPTH);
    assign outValid = cntQ != '0;
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;
    assign outData  = mem[rdQ];

    // storage has no reset: contents are only read once counted in
    always_ff @(posedge clk_sys)
        if (push)
            mem[wrQ] <= inData;

    // pointers and fill count
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            wrQ  <= '0;
            rdQ  <= '0;
            cntQ <= '0;
        end
        else
        begin
            if (push)
                wrQ <= (wrQ == AW'(DEPTH - 1)) ? '0 : wrQ + 1'b1;
            if (pop)
                rdQ <= (rdQ == AW'(DEPTH - 1)) ? '0 : rdQ + 1'b1;
            if (push && !pop)
                cntQ <= cntQ + 1'b1;
            else if (pop && !push)
                cntQ <= cntQ - 1'b1;
        end
    end
endmodule : sync_fifo

// File: logic/flash_read_device.sv
// read-command front end of a serial NOR flash, link end
// assumes the array answers arrayAddr combinationally on the link clock;
// all link logic runs on sclk and is cleared whenever chip select is high
//
// Operation
// - sample on sclk rise, drive on fall
// - address increments per byte, wraps to zero
// - read 03: opcode, address, data, no dummy
// - read 0B: one dummy byte before data
// - fast reads ignored during program/erase cycles
// - read 3B: eight dummies, data on two lanes
// - read 3B: opcode and address single lane
// - read BB: address on two lanes, dummies
// - host holds first dual dummy nibble steady
// - host sets quad enable before quad reads
// - read 6B: eight dummies, data on four lanes
// - read 6B: opcode and address single lane
// - read EB: address four lanes, 2+4 dummies
// - read EB: only opcode on single lane
// - opcode EB selects the quad I/O read
// - read EB also ignored during busy cycles
// - dummy select bit sets BB/EB dummy count
`timescale 1ns/1ps

module flash_read_device
    import flash_read_pkg::*;
(
    spi_link_if.device        link,       // serial link, device end
    output logic [ADDR_W-1:0] arrayAddr,  // current byte address
    input  logic [7:0]        arrayData,  // array byte at arrayAddr
    input  logic              progBusy,   // program/erase/status write running
    input  logic              dummySel    // dummy select bit
);

    // ----------------
    // state
    // ----------------
    devState_t       stateQ;
    logic [4:0]      cntQ;
    logic [7:0]      opShQ;
    logic [7:0]      opNext;
    logic [2:0]      aLanesQ;
    logic [2:0]      dLanesQ;
    logic [4:0]      aBeatsQ;
    logic [3:0]      dumQ;
    logic [2:0]      beatQ;
    logic            byteEnd;
    logic [ADDR_W-1:0] addrQ;
    logic            busyS1Q;
    logic            busyS2Q;
    logic            dcS1Q;
    logic            dcS2Q;
    logic [7:0]      shQ;
    logic [7:0]      curByte;
    logic [3:0]      outQ;
    logic [3:0]      oeQ;

    assign opNext    = {opShQ[6:0], link.io[0]};
    assign byteEnd   = beatQ == byteLast(dLanesQ);
    assign arrayAddr = addrQ;
    assign link.devOut = outQ;
    assign link.devOe  = oeQ;

    // ----------------
    // crossings
    // ----------------

    // busy and dummy select come from the array side; two flops each.
    // the sync refills within two edges, well before the opcode decode
    always_ff @(posedge link.sclk or posedge link.csN)
    begin
        if (link.csN)
        begin
            busyS1Q <= 1'b0;
            busyS2Q <= 1'b0;
            dcS1Q   <= 1'b0;
            dcS2Q   <= 1'b0;
        end
        else
        begin
            busyS1Q <= progBusy;
            busyS2Q <= busyS1Q;
            dcS1Q   <= dummySel;
            dcS2Q   <= dcS1Q;
        end
    end

    // ----------------
    // rising edge: phases
    // ----------------

    // chip select high is an async clear, so a frame cut mid-byte leaves
    // nothing behind and the next frame always starts at the opcode
    always_ff @(posedge link.sclk or posedge link.csN)
    begin
        if (link.csN)
        begin
            stateQ  <= ST_OPC;
            cntQ    <= '0;
            opShQ   <= '0;
            aLanesQ <= 3'h1;
            dLanesQ <= 3'h1;
            aBeatsQ <= '0;
            dumQ    <= '0;
            beatQ   <= '0;
        end
        else
        begin
            unique case (stateQ)
                ST_OPC:
                begin
                    opShQ <= opNext;
                    cntQ  <= cntQ + 1'b1;
                    if (cntQ == 5'(OPC_BEATS - 1))
                    begin
                        cntQ <= '0;
                        // unknown opcodes and fast reads under busy are dropped
                        if (!opValid(opNext) || (busyS2Q && opNext != OP_READ))
                            stateQ <= ST_IGNORE;
                        else
                        begin
                            stateQ  <= ST_ADDR;
                            aLanesQ <= addrLanes(opNext);
                            dLanesQ <= dataLanes(opNext);
                            aBeatsQ <= addrBeats(opNext);
                            dumQ    <= dummyBeats(opNext, dcS2Q);
                        end
                    end
                end
                ST_ADDR:
                begin
                    cntQ <= cntQ + 1'b1;
                    if (cntQ == aBeatsQ - 1'b1)
                    begin
                        cntQ   <= '0;
                        stateQ <= (dumQ == '0) ? ST_DATA : ST_DUMMY;
                    end
                end
                ST_DUMMY:
                begin
                    cntQ <= cntQ + 1'b1;
                    if (cntQ == 5'(dumQ) - 1'b1)
                    begin
                        cntQ   <= '0;
                        stateQ <= ST_DATA;
                    end
                end
                ST_DATA:
                    beatQ <= byteEnd ? '0 : beatQ + 1'b1;
                ST_IGNORE:
                    stateQ <= ST_IGNORE;
            endcase
        end
    end

    // ----------------
    // rising edge: address
    // ----------------

    // address shifts in on the lanes of the address phase, then counts
    // bytes; the counter width makes the top address roll over to zero
    always_ff @(posedge link.sclk or posedge link.csN)
    begin
        if (link.csN)
            addrQ <= '0;
        else if (stateQ == ST_ADDR)
        begin
            unique case (aLanesQ)
                3'h2:    addrQ <= {addrQ[ADDR_W-3:0], link.io[1:0]};
                3'h4:    addrQ <= {addrQ[ADDR_W-5:0], link.io[3:0]};
                default: addrQ <= {addrQ[ADDR_W-2:0], link.io[0]};
            endcase
        end
        else if (stateQ == ST_DATA && byteEnd)
            addrQ <= addrQ + 1'b1;
    end

    // ----------------
    // falling edge: data out
    // ----------------

    // a fresh byte is taken from the array at beat zero; later beats
    // come from the shift register
    always_comb
    begin
        curByte = (beatQ == '0) ? arrayData : shQ;
    end

    // lanes change only on the falling edge, so the host sees a full
    // half period of setup before its sampling edge
    always_ff @(negedge link.sclk or posedge link.csN)
    begin
        if (link.csN)
        begin
            shQ  <= '0;
            outQ <= '0;
            oeQ  <= '0;
        end
        else if (stateQ == ST_DATA)
        begin
            shQ <= 8'(curByte << dLanesQ);
            unique case (dLanesQ)
                3'h2:
                begin
                    outQ <= {2'h0, curByte[7:6]};
                    oeQ  <= 4'h3;
                end
                3'h4:
                begin
                    outQ <= curByte[7:4];
                    oeQ  <= 4'hF;
                end
                default:
                begin
                    outQ <= {2'h0, curByte[7], 1'b0};
                    oeQ  <= 4'h2;
                end
            endcase
        end
    end

endmodule : flash_read_device

// File: logic/flash_read_host.sv
// host end of the serial flash read link: frames read commands,
// makes sclk by dividing clk_sys, and buffers returned bytes
// assumes the device samples on sclk rise and drives on sclk fall
`timescale 1ns/1ps

module flash_read_host
    import flash_read_pkg::*;
#(
    parameter int LEN_W     = 12,
    parameter int SCLK_HALF = SCLK_HALF_CYC
) (
    input  logic              clk_sys,     // system clock
    input  logic              srst,        // sync reset
    spi_link_if.host          link,        // serial link, host end
    input  logic              cmdValid,    // command request
    output logic              cmdReady,    // host idle
    input  logic [7:0]        cmdOp,       // read opcode
    input  logic [ADDR_W-1:0] cmdAddr,     // start address
    input  logic [LEN_W-1:0]  cmdLen,      // bytes to read
    input  logic              quadEnabled, // quad enable bit is set
    input  logic              dummySel,    // dummy select bit copy
    output logic              cmdRefused,  // command dropped
    output logic              rdValid,     // read byte waiting
    input  logic              rdReady,     // read byte taken
    output logic [7:0]        rdData       // read byte
);
    localparam int BEAT_W = LEN_W + 4;

    hostState_t        stateQ;
    logic [4:0]        tickQ;
    logic              sclkQ, csNQ;
    logic [3:0]        outQ, oeQ, ioS1Q, ioS2Q;
    logic [31:0]       txQ, txNext;
    logic [BEAT_W-1:0] beatQ, nb, aEndQ, dStartQ, lastQ, cAEnd, cDStart;
    logic [2:0]        aLanesQ, dLanesQ, rxCntQ;
    logic [7:0]        rxShQ, rxNext, rxByteQ;
    logic [3:0]        drvOut, drvOe;
    logic              tickEnd, dataBeat, stall, riseGo, pushQ, fifoReady, refusedQ;

    assign link.sclk    = sclkQ;
    assign link.csN     = csNQ;
    assign link.hostOut = outQ;
    assign link.hostOe  = oeQ;
    assign cmdReady     = stateQ == H_IDLE;
    assign cmdRefused   = refusedQ;
    assign tickEnd  = tickQ == 5'(SCLK_HALF - 1);
    assign dataBeat = beatQ >= dStartQ;
    // a byte may not complete while the FIFO is full: sclk is held low
    assign stall    = dataBeat && rxCntQ == byteLast(dLanesQ) && !fifoReady;
    assign riseGo   = stateQ == H_RUN && tickEnd && !sclkQ && !stall;
    assign cAEnd    = BEAT_W'(OPC_BEATS) + BEAT_W'(addrBeats(cmdOp));
    assign cDStart  = cAEnd + BEAT_W'(dummyBeats(cmdOp, dummySel));

    // lane levels are pins: two flops before use
    always_ff @(posedge clk_sys)
    begin
        ioS1Q <= link.io;
        ioS2Q <= ioS1Q;
    end

    // what to drive for the next beat; dummies are all-zero nibbles
    always_comb
    begin
        nb     = beatQ + 1'b1;
        drvOut = 4'h0;
        drvOe  = 4'h0;
        txNext = txQ;
        if (nb < BEAT_W'(OPC_BEATS))
        begin
            drvOut = {3'h0, txQ[31]};
            drvOe  = 4'h1;
            txNext = {txQ[30:0], 1'b0};
        end
        else if (nb < aEndQ)
        begin
            drvOut = (aLanesQ == 3'h4) ? txQ[31:28] : (aLanesQ == 3'h2) ? {2'h0, txQ[31:30]} : {3'h0, txQ[31]};
            drvOe  = laneMask(aLanesQ);
            txNext = txQ << aLanesQ;
        end
        else if (nb < dStartQ)
            drvOe = laneMask(aLanesQ);
        rxNext = (dLanesQ == 3'h4) ? {rxShQ[3:0], ioS2Q} :
                 (dLanesQ == 3'h2) ? {rxShQ[5:0], ioS2Q[1:0]} : {rxShQ[6:0], ioS2Q[1]};
    end

    // frame sequencing and clock divider; sclk idles low
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            stateQ   <= H_IDLE;
            tickQ    <= '0;
            sclkQ    <= 1'b0;
            csNQ     <= 1'b1;
            outQ     <= '0;
            oeQ      <= '0;
            txQ      <= '0;
            beatQ    <= '0;
            refusedQ <= 1'b0;
            aEndQ    <= '0;
            dStartQ  <= '0;
            lastQ    <= '0;
            aLanesQ  <= 3'h1;
            dLanesQ  <= 3'h1;
        end
        else
        begin
            refusedQ <= 1'b0;
            unique case (stateQ)
                H_IDLE:
                    if (cmdValid)
                    begin
                        if (!opValid(cmdOp) || (isQuad(cmdOp) && !quadEnabled))
                            refusedQ <= 1'b1;
                        else
                        begin
                            stateQ  <= H_RUN;
                            csNQ    <= 1'b0;
                            tickQ   <= '0;
                            beatQ   <= '0;
                            outQ    <= {3'h0, cmdOp[7]};
                            oeQ     <= 4'h1;
                            // address msb must follow the opcode lsb with no gap bit
                            txQ     <= {cmdOp[6:0], cmdAddr, 1'b0};
                            aLanesQ <= addrLanes(cmdOp);
                            dLanesQ <= dataLanes(cmdOp);
                            aEndQ   <= cAEnd;
                            dStartQ <= cDStart;
                            lastQ   <= cDStart + (BEAT_W'(cmdLen) << (3'h3 - (dataLanes(cmdOp) >> 1))) - 1'b1;
                        end
                    end
                H_RUN:
                    if (!tickEnd)
                        tickQ <= tickQ + 1'b1;
                    else if (!sclkQ)
                    begin
                        if (!stall)
                        begin
                            sclkQ <= 1'b1;
                            tickQ <= '0;
                        end
                    end
                    else
                    begin
                        sclkQ <= 1'b0;
                        tickQ <= '0;
                        if (beatQ == lastQ)
                        begin
                            stateQ <= H_GAP;
                            csNQ   <= 1'b1;
                            oeQ    <= '0;
                        end
                        else
                        begin
                            beatQ <= nb;
                            outQ  <= drvOut;
                            oeQ   <= drvOe;
                            txQ   <= txNext;
                        end
                    end
                H_GAP:
                begin
                    // keeps chip select high for a half period between frames
                    tickQ <= tickQ + 1'b1;
                    if (tickEnd)
                        stateQ <= H_IDLE;
                end
            endcase
        end
    end

    // data capture on each sclk rise of the data phase; a full byte is pushed once
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            rxCntQ  <= '0;
            rxShQ   <= '0;
            rxByteQ <= '0;
            pushQ   <= 1'b0;
        end
        else
        begin
            pushQ <= 1'b0;
            if (stateQ == H_IDLE)
                rxCntQ <= '0;
            else if (riseGo && dataBeat)
            begin
                rxShQ  <= rxNext;
                rxCntQ <= rxCntQ + 1'b1;
                if (rxCntQ == byteLast(dLanesQ))
                begin
                    rxCntQ  <= '0;
                    rxByteQ <= rxNext;
                    pushQ   <= 1'b1;
                end
            end
        end
    end

    sync_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rxFifo (
        .clk_sys  (clk_sys),
        .srst     (srst),
        .inValid  (pushQ),
        .inReady  (fifoReady),
        .inData   (rxByteQ),
        .outValid (rdValid),
        .outReady (rdReady),
        .outData  (rdData)
    );
endmodule : flash_read_host

// File: sim/flash_link_checker.sv
// link assertions for the flash read pair, sampled on clk_sys
// assumes sclk is slow against clk_sys, so every link edge is seen
`timescale 1ns/1ps

module flash_link_checker (
    input logic       clk_sys, // system clock
    input logic       srst,    // sync reset
    input logic       sclk,    // serial clock
    input logic       csN,     // chip select
    input logic [3:0] hostOe,  // host enables
    input logic [3:0] devOut,  // device lanes
    input logic [3:0] devOe    // device enables
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);

    // first eight clk_sys cycles after select: one host lane, device silent
    sequence opcodeBeats;
        (hostOe == 4'h1 && devOe == 4'h0) [*8];
    endsequence

    // ----------------
    // lanes
    // ----------------
    oe_release_a: assert property (csN |-> devOe == 4'h0)
        else $error("device drives while deselected");
    no_clash_a: assert property ((devOe & hostOe) == 4'h0)
        else $error("both ends drive one lane");
    dev_lanes_a: assert property (devOe inside {4'h0, 4'h2, 4'h3, 4'hF})
        else $error("device lane set wrong");
    host_lanes_a: assert property (hostOe inside {4'h0, 4'h1, 4'h3, 4'hF})
        else $error("host lane set wrong");
    opcode_lane_a: assert property ($fell(csN) |-> opcodeBeats)
        else $error("opcode not on one lane");
    // a device enable once raised must hold to the end of the frame
    oe_hold_a: assert property (!csN && $past(!csN) && $past(|devOe) |-> devOe == $past(devOe))
        else $error("device lanes dropped mid frame");
    // ----------------
    // edges
    // ----------------
    fall_change_a: assert property (!csN && $changed(devOut) |-> !sclk)
        else $error("device lane changed off falling edge");
    clock_idle_a: assert property (csN |-> !sclk)
        else $error("sclk runs outside frame");
endmodule : flash_link_checker

// File: sim/testbench.sv
// self-checking bench: host and device joined by the link interface
// assumes a combinational array model and a short sclk divider
`timescale 1ns/1ps

module testbench import flash_read_pkg::*; ;
    logic clk_sys, srst, cmdValid, cmdReady, cmdRefused, quadEnabled;
    logic dummySel, progBusy, rdValid, rdReady;
    logic [7:0]  cmdOp, rdData, arrayData;
    logic [23:0] cmdAddr, arrayAddr;
    logic [11:0] cmdLen;
    int failures, num_checks, cycles;
    localparam logic [7:0] OPS [6] = '{OP_READ, OP_DUMMY_READ, OP_DUAL_OUT, OP_DUAL_IO, OP_QUAD_OUT, OP_QUAD_IO};

    spi_link_if link();
    flash_read_host #(.SCLK_HALF(4)) flash_read_host_i (.clk_sys(clk_sys), .srst(srst), .link(link),
        .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdLen(cmdLen),
        .quadEnabled(quadEnabled), .dummySel(dummySel), .cmdRefused(cmdRefused), .rdValid(rdValid),
        .rdReady(rdReady), .rdData(rdData));
    flash_read_device flash_read_device_i (.link(link), .arrayAddr(arrayAddr), .arrayData(arrayData),
        .progBusy(progBusy), .dummySel(dummySel));
    flash_link_checker flash_link_checker_i (.clk_sys(clk_sys), .srst(srst), .sclk(link.sclk),
        .csN(link.csN), .hostOe(link.hostOe), .devOut(link.devOut), .devOe(link.devOe));

    // array model: a pattern that differs between neighbouring addresses, except 7FFFFF/800000 and FFFFFF/000000
    function automatic logic [7:0] memByte(input logic [23:0] a);
        return a[7:0] ^ a[23:16] ^ 8'h3C;
    endfunction : memByte
    assign arrayData = memByte(arrayAddr);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict

    // one command, held until the accept edge
    task automatic issue(input logic [7:0] op, input logic [23:0] addr, input int len);
        @(posedge clk_sys);
        while (cmdReady !== 1'b1)
            @(posedge clk_sys);
        cmdValid <= 1'b1;
        cmdOp    <= op;
        cmdAddr  <= addr;
        cmdLen   <= 12'(len);
        @(posedge clk_sys);
        cmdValid <= 1'b0;
    endtask : issue

    // read len bytes; blank expects the pulled-up idle lanes
    task automatic doRead(input logic [7:0] op, input logic [23:0] addr, input int len, input int stall,
                          input logic blank);
        int n;
        n = 0;
        rdReady <= (stall == 0);
        issue(op, addr, len);
        repeat (stall) @(posedge clk_sys);
        if (stall > 0)
            check(link.csN, 1'b0);
        rdReady <= 1'b1;
        while (n < len)
        begin
            @(posedge clk_sys);
            if (rdValid === 1'b1 && rdReady)
            begin
                check(rdData, blank ? 8'hFF : memByte(24'(addr + n)));
                n++;
            end
        end
    endtask : doRead

    // every opcode, both dummy settings, crossing the top address
    task automatic testOps();
        for (int i = 0; i < 12; i++)
        begin
            dummySel <= (i > 5);
            doRead(OPS[i % 6], 24'hFFFFFD, 5, 0, 1'b0);
        end
    endtask : testOps

    // quad without enable and an unknown opcode make no frame
    task automatic testRefuse();
        logic [7:0] bad [3] = '{OP_QUAD_OUT, OP_QUAD_IO, 8'h05};
        int seen;
        quadEnabled <= 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            seen = 0;
            issue(bad[i], 24'h0, 2);
            repeat (6)
            begin
                @(posedge clk_sys);
                seen += int'(cmdRefused === 1'b1);
                check(link.csN, 1'b1);
            end
            check(seen, 1);
        end
        quadEnabled <= 1'b1;
    endtask : testRefuse

    // fast reads are ignored while busy, plain read still served
    task automatic testBusy();
        progBusy <= 1'b1;
        for (int i = 0; i < 6; i++)
            doRead(OPS[i], 24'h000100, 2, 0, OPS[i] != OP_READ);
        progBusy <= 1'b0;
    endtask : testBusy

    // fifo fills while the reader stalls, then drains in order
    task automatic testFull();
        doRead(OP_DUAL_OUT, 24'h00ABC0, 40, 2500, 1'b0);
        // a frame cut before its data must leave the next frame decoding fresh
        doRead(OP_QUAD_IO, 24'h000040, 0, 0, 1'b0);
        doRead(OP_QUAD_OUT, 24'h000010, 3, 0, 1'b0);
    endtask : testFull

    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // cut a hang short: the whole run needs well under this
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            failures++;
            print_verdict();
        end
    end

    initial
    begin
        {srst, quadEnabled} = 2'h3;
        {cmdValid, dummySel, progBusy, rdReady} = 4'h0;
        {cmdOp, cmdAddr, cmdLen} = 44'h0;
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        testOps();
        testRefuse();
        testBusy();
        testFull();
        print_verdict();
    end
endmodule : testbench
